// *** design/two_bit_port_edge_interrupt.v ***
// Two-pin bidirectional port with routable edge interrupt and APB registers
`include "port2_map.vh"

// How it works
// - Latch register read returns live pin levels
// - Read-modify-write operand uses stored latch bits
// - Pin input sampling always enabled
// - Direction bit one is output, zero input
// - Pull-up only when direction zero, latch one
// - Output zero drives low; one high or open
// - Rising and falling enables pick edge mode
// - Matching edge on selected pin sets flag
// - Flag and enable raise request, and wake in deep standby
// - Deep standby blocks edges toward entry level
// - Flag cleared only by software write
// - Pin route selects first or second pin
// - Side function routes edges to timers
// - Routed capture overrides other capture pins
// - Timer one low counts events or every two
// - Standby freezes pin drive and pull-up
// - Wake enters clock-running standby on oscillator
// - Output type fixed per bit by option
module two_bit_port_edge_interrupt #(
  parameter [1:0] OPEN_DRAIN = 2'h0
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire [1:0] pin_in,
  output reg [1:0] pin_out,
  output reg [1:0] pin_oe,
  output reg [1:0] pullup_en,
  input wire halt_mode,
  input wire hold_mode,
  input wire other_t0l_capture,
  input wire other_t0h_capture,
  output wire int_request,
  output wire [15:0] int_vector,
  output wire hold_release,
  output wire rc_halt_request,
  output reg t1_count,
  output reg t0l_capture,
  output reg t0h_capture
);

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  reg [1:0] latch_reg;
  reg [1:0] direction_reg;
  reg [3:0] ctrl_reg;
  reg [3:0] select_reg;
  reg [1:0] sync1_reg;
  reg [1:0] sync2_reg;
  reg [1:0] prev_reg;
  reg [1:0] entry_level_reg;
  reg hold_prev_reg;
  reg t1_div_reg;
  reg [3:0] ctrl_next;
  reg [31:0] rdata_next;
  reg decode_hit;

  wire standby = halt_mode | hold_mode;
  wire setup = psel & ~penable;
  wire wr = psel & penable & pwrite;
  wire [`IDX_WIDTH-1:0] idx = paddr[`IDX_WIDTH+1:2];
  wire addr_ok = (paddr[1:0] == `ADDR_LOW_ZERO) &&
                 (paddr[31:`IDX_WIDTH+2] == {(30-`IDX_WIDTH){1'b0}});

  assign pready = 1'b1;

  // -------------------------------------------------------------------------
  // Pin synchroniser and edge detection
  // -------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= `PORT_BITS_RESET;
      sync2_reg <= `PORT_BITS_RESET;
      prev_reg <= `PORT_BITS_RESET;
    end else begin
      // Sampling never gated by direction, so output pins read back too
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Inhibited route codes select no pin at all
  wire route_ok = ~select_reg[`PIN_ROUTE_HI_BIT];
  wire route_pin = select_reg[`PIN_ROUTE_LO_BIT];
  wire cur_lvl = sync2_reg[route_pin];
  wire old_lvl = prev_reg[route_pin];
  wire entry_lvl = entry_level_reg[route_pin];

  // In deep standby an edge back toward the entry level cannot set the flag
  wire rise = route_ok & cur_lvl & ~old_lvl &
              ~(hold_mode & entry_lvl);
  wire fall = route_ok & ~cur_lvl & old_lvl &
              ~(hold_mode & ~entry_lvl);
  wire edge_hit = (rise & ctrl_reg[`RISING_EDGE_ENABLE_BIT]) |
                  (fall & ctrl_reg[`FALLING_EDGE_ENABLE_BIT]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_prev_reg <= 1'b0;
      entry_level_reg <= `PORT_BITS_RESET;
    end else begin
      hold_prev_reg <= hold_mode;
      if (hold_mode & ~hold_prev_reg) begin
        entry_level_reg <= sync2_reg;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Register writes
  // -------------------------------------------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr && addr_ok && idx == `EDGE_CTRL_IDX) begin
      ctrl_next = pwdata[3:0];
    end
    // A fresh edge beats a clear in the same cycle; no hardware clear
    if (edge_hit) begin
      ctrl_next[`EDGE_SOURCE_FLAG_BIT] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_reg <= `PORT_BITS_RESET;
      direction_reg <= `PORT_BITS_RESET;
      ctrl_reg <= `CTRL_RESET;
      select_reg <= `CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      if (wr && addr_ok) begin
        // Writes to either latch view land in the stored latch
        if (idx == `PORT_OUTPUT_LATCH_IDX || idx == `LATCH_OPERAND_IDX) begin
          latch_reg <= pwdata[1:0];
        end
        if (idx == `PORT_DIRECTION_IDX) begin
          direction_reg <= pwdata[1:0];
        end
        // Upper fixed bits are not stored and always read zero
        if (idx == `EDGE_PIN_SELECT_IDX) begin
          select_reg <= pwdata[3:0];
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Read path, registered in the setup cycle so the access needs no wait
  // -------------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    decode_hit = addr_ok;
    case (idx)
      `PORT_OUTPUT_LATCH_IDX: begin
        rdata_next[7:0] = {`PORT_UNUSED_READ, sync2_reg};
      end
      `LATCH_OPERAND_IDX: begin
        // Operand view for bit-set, clear, toggle and inc/dec sequences
        rdata_next[7:0] = {`PORT_UNUSED_READ, latch_reg};
      end
      `PORT_DIRECTION_IDX: begin
        rdata_next[7:0] = {`PORT_UNUSED_READ, direction_reg};
      end
      `EDGE_CTRL_IDX: begin
        rdata_next[7:0] = {`WRITE_ZERO_BITS_READ, ctrl_reg};
      end
      `EDGE_PIN_SELECT_IDX: begin
        rdata_next[7:0] = {`WRITE_ZERO_BITS_READ, select_reg};
      end
      default: begin
        decode_hit = 1'b0;
      end
    endcase
    if (!addr_ok) begin
      rdata_next = 32'h0000_0000;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= rdata_next;
      pslverr <= ~decode_hit;
    end
  end

  // -------------------------------------------------------------------------
  // Pin drive, frozen while in either standby mode
  // -------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin_drive
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out[g] <= 1'b0;
          pin_oe[g] <= 1'b0;
          pullup_en[g] <= 1'b0;
        end else if (!standby) begin
          pin_out[g] <= latch_reg[g];
          // Open-drain option releases the pin for a one
          pin_oe[g] <= direction_reg[g] &
                       ~(latch_reg[g] & OPEN_DRAIN[g]);
          pullup_en[g] <= ~direction_reg[g] & latch_reg[g];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------------
  // Interrupt request, wake and timer side functions
  // -------------------------------------------------------------------------
  wire request = ctrl_reg[`EDGE_SOURCE_FLAG_BIT] &
                 ctrl_reg[`EDGE_REQUEST_ENABLE_BIT];
  assign int_request = request;
  assign int_vector = `INT_VECTOR;
  assign hold_release = request & hold_mode;
  // The clock controller then idles the CPU on the RC oscillator
  assign rc_halt_request = request & hold_mode;

  wire [1:0] side = {select_reg[`SIDE_FUNCTION_HI_BIT],
                     select_reg[`SIDE_FUNCTION_LO_BIT]};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_div_reg <= 1'b0;
      t1_count <= 1'b0;
      t0l_capture <= 1'b0;
      t0h_capture <= 1'b0;
    end else begin
      // Free-running tick every two cycles unless edges are routed to timer one
      if (t1_div_reg == 1'b1) begin
        t1_div_reg <= 1'b0;
      end else begin
        t1_div_reg <= 1'b1;
      end
      if (side == `SIDE_T1_COUNT) begin
        t1_count <= edge_hit;
      end else begin
        t1_count <= t1_div_reg;
      end
      // Other capture pins are ignored while this source owns the capture
      if (side == `SIDE_T0L_CAPTURE) begin
        t0l_capture <= edge_hit;
      end else begin
        t0l_capture <= other_t0l_capture;
      end
      if (side == `SIDE_T0H_CAPTURE) begin
        t0h_capture <= edge_hit;
      end else begin
        t0h_capture <= other_t0h_capture;
      end
    end
  end

endmodule

// *** include/port2_map.vh ***
// Register indices, field positions and timing constants of the two-pin port
`ifndef PORT2_MAP_VH
`define PORT2_MAP_VH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define PORT_OUTPUT_LATCH_IDX 16'hFE48
`define PORT_DIRECTION_IDX 16'hFE49
`define EDGE_CTRL_IDX 16'hFE4A
`define EDGE_PIN_SELECT_IDX 16'hFE4B
`define LATCH_OPERAND_IDX 16'hFE4C
`define IDX_WIDTH 16
`define ADDR_LOW_ZERO 2'h0

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define RISING_EDGE_ENABLE_BIT 3
`define FALLING_EDGE_ENABLE_BIT 2
`define EDGE_SOURCE_FLAG_BIT 1
`define EDGE_REQUEST_ENABLE_BIT 0
`define PIN_ROUTE_HI_BIT 3
`define PIN_ROUTE_LO_BIT 2
`define SIDE_FUNCTION_HI_BIT 1
`define SIDE_FUNCTION_LO_BIT 0

// ---------------------------------------------------------------------------
// Side function codes
// ---------------------------------------------------------------------------
`define SIDE_NONE 2'h0
`define SIDE_T1_COUNT 2'h1
`define SIDE_T0L_CAPTURE 2'h2
`define SIDE_T0H_CAPTURE 2'h3

// ---------------------------------------------------------------------------
// Reset values and fixed read values
// ---------------------------------------------------------------------------
`define PORT_BITS_RESET 2'h0
`define CTRL_RESET 4'h0
`define PORT_UNUSED_READ 6'h3F
`define WRITE_ZERO_BITS_READ 4'h0
`define INT_VECTOR 16'h0013

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define T1_FREE_RUN_TCYC 2

`endif

// *** verification/port2_chk.sv ***
// Concurrent checks on the ports of the two-pin port
module port2_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [1:0] pin_out,
  input wire [1:0] pin_oe,
  input wire [1:0] pullup_en,
  input wire halt_mode,
  input wire hold_mode,
  input wire int_request,
  input wire [15:0] int_vector,
  input wire hold_release,
  input wire rc_halt_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire stby = halt_mode | hold_mode;
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  vector_fixed_a: assert property (int_vector == 16'h0013)
    else $error("vector wrong");
  wake_level_a: assert property (
    hold_release == (int_request && hold_mode))
    else $error("wake level wrong");
  rc_halt_a: assert property (rc_halt_request == hold_release)
    else $error("halt request wrong");
  pull_input_a: assert property ((pullup_en & pin_oe) == 2'h0)
    else $error("pull-up on output");
  no_wait_a: assert property (psel && penable |-> pready)
    else $error("wait state");
  bad_addr_a: assert property (
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned accepted");
  stby_hold_a: assert property (stby && $past(stby) |->
    $stable(pin_oe) && $stable(pullup_en) && $stable(pin_out))
    else $error("pins moved in standby");
  flag_sticky_a: assert property ($fell(int_request) |->
    $past(psel && penable && pwrite))
    else $error("request fell alone");
  cover property ($rose(int_request));
  cover property (hold_release);
  cover property (pslverr);
endmodule

// *** verification/pin_world.sv ***
// Far-side model of the two port pins
module pin_world (
  input wire pclk,
  input wire [1:0] pin_out,
  input wire [1:0] pin_oe,
  input wire [1:0] pullup_en,
  input wire [1:0] ext_en,
  input wire [1:0] ext_val,
  output logic [1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wobble = 2'h1;
  // A floating pin must not look stable, so it changes every cycle
  always @(posedge pclk) wobble <= ~wobble;
  always_comb
    for (int i = 0; i < 2; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pullup_en[i] ? 1'b1 : wobble[i];
endmodule

// *** verification/two_bit_port_edge_interrupt_bench.sv ***
// Self-checking bench for the two-pin port
module two_bit_port_edge_interrupt_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] A_LAT = 32'h0003F920;
  localparam [31:0] A_DIR = 32'h0003F924;
  localparam [31:0] A_CTL = 32'h0003F928;
  localparam [31:0] A_SEL = 32'h0003F92C;
  localparam [31:0] A_OPR = 32'h0003F930;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic halt_mode = '0, hold_mode = '0;
  logic other_t0l_capture = '0, other_t0h_capture = '0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [1:0] pin_in, pin_out, pin_oe, pullup_en, lat, dir;
  logic [1:0] ext_en = '0, ext_val = '0;
  logic [15:0] int_vector;
  wire pready, pslverr, int_request, hold_release, rc_halt_request;
  wire t1_count, t0l_capture, t0h_capture;
  int miscompares = 0, comparisons = 0, n1 = 0, nl = 0, nh = 0, b1, bl, bh;
  two_bit_port_edge_interrupt dut_u (.*);
  pin_world pw_u (.*);
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    n1 <= n1 + t1_count;
    nl <= nl + t0l_capture;
    nh <= nh + t0h_capture;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] pins_exp(logic [1:0] d, l, e);
    return {24'h0, 6'h3F, (d & l) | (~d & e)};
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic hit(int r, logic v, logic e);
    ext_val[1-r] <= v;
    repeat (5) @(posedge pclk);
    apb(0, A_CTL, 0);
    chk(rd[1], 0);
    ext_val[r] <= v;
    repeat (5) @(posedge pclk);
    apb(0, A_CTL, 0);
    chk(rd[1], e);
    chk(int_request, e);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200us;
    miscompares++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h7F546B09));
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(0, A_CTL, 0);
    chk(rd, 0);
    apb(0, A_DIR, 0);
    chk(rd, 32'hFC);
    apb(0, 32'h0003F922, 0);
    chk(pslverr, 1);
    chk(rd, 0);
    repeat (20) begin
      lat = $urandom;
      dir = $urandom;
      ext_en <= ~dir;
      ext_val <= $urandom;
      apb(1, A_LAT, lat);
      apb(1, A_DIR, dir);
      repeat (4) @(posedge pclk);
      chk(pin_oe, dir);
      chk(pullup_en, ~dir & lat);
      chk(pin_out & dir, lat & dir);
      apb(0, A_LAT, 0);
      chk(rd, pins_exp(dir, lat, ext_val));
      apb(0, A_OPR, 0);
      chk(rd[1:0], lat);
    end
    apb(1, A_DIR, 0);
    ext_en <= 2'h3;
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 4; m++) begin
        apb(1, A_CTL, 0);
        ext_val <= 2'h0;
        apb(1, A_SEL, r << 2);
        repeat (4) @(posedge pclk);
        apb(1, A_CTL, m << 2 | 1);
        hit(r, 1, m[1]);
        apb(1, A_CTL, m << 2 | 1);
        hit(r, 0, m[0]);
      end
    apb(1, A_CTL, 32'hC);
    other_t0l_capture <= 1'h1;
    other_t0h_capture <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      apb(1, A_SEL, s);
      repeat (4) @(posedge pclk);
      b1 = n1;
      bl = nl;
      bh = nh;
      repeat (20) @(posedge pclk);
      ext_val[0] <= ~ext_val[0];
      repeat (10) @(posedge pclk);
      chk(n1 - b1, s == 1 ? 1 : 15);
      chk(nl - bl, s == 2 ? 1 : 30);
      chk(nh - bh, s == 3 ? 1 : 30);
    end
    apb(1, A_SEL, 0);
    ext_val <= 2'h1;
    // Let the rising edge settle before the flag is cleared
    repeat (5) @(posedge pclk);
    apb(1, A_CTL, 32'h9);
    hold_mode <= 1'h1;
    repeat (3) @(posedge pclk);
    ext_val <= 2'h0;
    repeat (5) @(posedge pclk);
    ext_val <= 2'h1;
    repeat (5) @(posedge pclk);
    chk(hold_release, 0);
    apb(1, A_CTL, 32'h5);
    ext_val <= 2'h0;
    apb(1, A_DIR, 3);
    repeat (4) @(posedge pclk);
    chk({hold_release, pin_oe}, 3'h4);
    hold_mode <= 1'h0;
    repeat (3) @(posedge pclk);
    chk(pin_oe, 3);
    end_of_test;
  end
endmodule
bind two_bit_port_edge_interrupt port2_chk chk_u (.*);
